// [bench/host_bus_port_tb.sv]
// randomised self-checking bench for the host port
`timescale 1ns/1ns
module host_bus_port_tb;
	// ==========================================
	// signals
	logic clk_sys, rst_n, master_reset, chip_select_n, read_strobe_n, write_strobe_n;
	logic irq_ack_in_n, host_data_oe, bus_ack_n_out, bus_ack_n_oe, irq_out_n_out;
	logic irq_out_n_oe, reg_rd_stb, reg_wr_stb, osc_div_wr, dack_disable, dack_enable;
	logic vector_modify;
	logic [1:0] mr_ptr;
	logic [5:0] reg_addr_in, reg_addr, irq_threshold, a;
	logic [7:0] host_data_in, host_data_out, reg_wdata, reg_rdata, osc_div, osc_div_wdata;
	logic [7:0] irq_vector, current_interrupt_reg, clk_cnt, rd, d;
	logic [3:0][5:0] src_level;
	logic [3:0] src_enable, serial_tx_out, serial_rx_in, chan_tx_data, chan_rx_data;
	logic [3:0] io0_gp_out, io1_gp_out, tx_clk_1x, tx_clk_16x, rx_clk_1x, rx_clk_16x, ct_out;
	logic [3:0] multi_pin_zero_in, multi_pin_zero_out, multi_pin_zero_oe, multi_pin_one_in;
	logic [3:0] multi_pin_one_out, multi_pin_one_oe, io0_level, io1_level, io0_cos, io1_cos;
	logic [3:0] cts_n, ext_tx_clk, ext_tx_16x, ct_in, pin0, pin1;
	host_port_pkg::io0_mode_type io0_mode [4];
	host_port_pkg::io1_mode_type io1_mode [4];
	logic [7:0] regs [64];
	logic [7:0] expv [64];
	logic [8:0] w;
	bit         acked, oe_seen, released;
	int         seed, fail_count, n_tests, i, c, k;
	host_bus_port dut (.*);
	host_model host (.*);
	// ==========================================
	// surroundings: clocks, pins with pull-ups, register file
	assign tx_clk_1x = clk_cnt[7:4];
	assign tx_clk_16x = clk_cnt[3:0];
	assign rx_clk_1x = ~clk_cnt[7:4];
	assign rx_clk_16x = ~clk_cnt[3:0];
	assign reg_rdata = regs[reg_addr];
	assign multi_pin_zero_in = (multi_pin_zero_oe & multi_pin_zero_out) | (~multi_pin_zero_oe & pin0);
	assign multi_pin_one_in = (multi_pin_one_oe & multi_pin_one_out) | (~multi_pin_one_oe & pin1);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(negedge clk_sys) clk_cnt <= clk_cnt + 8'h01;
	always @(posedge clk_sys) if (reg_wr_stb === 1'b1) regs[reg_addr] <= reg_wdata;
	// ==========================================
	// helpers
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic nclk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// {any, channel, level}: highest enabled level above threshold, lowest index on tie
	function automatic logic [8:0] winner();
		logic [8:0] r;
		r = 9'h000;
		for (int j = 0; j < 4; j++)
			if (src_enable[j] && src_level[j] > irq_threshold && (!r[8] || src_level[j] > r[5:0]))
				r = {1'b1, 2'(j), src_level[j]};
		return r;
	endfunction
	initial begin
		#80000;
		fail_count++;
		wrap_up;
	end
	// ==========================================
	// main sequence
	initial begin
		seed = 78;
		{fail_count, n_tests, clk_cnt} = 72'h0;
		{rst_n, master_reset, osc_div_wr, dack_disable, vector_modify} = 5'h00;
		{osc_div_wdata, irq_vector, src_level, src_enable, irq_threshold} = 50'h0;
		{chan_tx_data, serial_rx_in, pin0, pin1, io0_gp_out, io1_gp_out, ct_out} = 28'hffff000;
		for (i = 0; i < 64; i++) {regs[i], expv[i]} = 16'h0000;
		for (i = 0; i < 4; i++) begin
			io0_mode[i] = host_port_pkg::IO0_GP_IN;
			io1_mode[i] = host_port_pkg::IO1_GP_IN;
		end
		nclk(12);
		check({osc_div, mr_ptr, dack_enable, serial_tx_out}, {8'h01, 2'h0, 1'b1, 4'hf});
		check({multi_pin_zero_oe, multi_pin_one_oe, host_data_oe, bus_ack_n_oe}, 10'h000);
		rst_n = 1'b1;
		for (i = 0; i < 24; i++) begin
			a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
			d = 8'($random(seed));
			host.cycle(1, a, d, rd, acked, oe_seen, released);
			expv[a] = d;
			check({acked, oe_seen, released}, 3'b101);
			// back-to-back read of the same place, then a random one
			for (k = 0; k < 2; k++) begin
				if (k == 1) a = 6'($random(seed));
				host.cycle(0, a, 8'h00, rd, acked, oe_seen, released);
				check({acked, oe_seen, rd}, {2'b11, expv[a]});
				check(released, 1'b1);
			end
		end
		for (i = 0; i < 20; i++) begin
			src_level = 24'($random(seed));
			src_enable = 4'($random(seed));
			irq_threshold = 6'($random(seed));
			nclk(2);
			w = winner();
			check(irq_out_n_oe, w[8]);
		end
		for (i = 0; i < 4; i++) begin
			src_level = 24'($random(seed)) | 24'h041041;
			{src_enable, irq_threshold} = 10'h3c0;
			irq_vector = 8'($random(seed));
			vector_modify = i[0];
			nclk(2);
			w = winner();
			host.cycle(2, 6'h00, 8'h00, rd, acked, oe_seen, released);
			check({acked, released, rd}, {2'b11, i[0] ? {irq_vector[7:2], w[7:6]} : irq_vector});
			check(current_interrupt_reg, w[7:0]);
		end
		for (i = 0; i < 8; i++) begin
			chan_tx_data = 4'($random(seed));
			serial_rx_in = 4'($random(seed));
			nclk(3);
			check({serial_tx_out, chan_rx_data}, {chan_tx_data, serial_rx_in});
		end
		for (c = 0; c < 4; c++) begin
			io0_mode[c] = c[1] ? host_port_pkg::IO0_TXC16_OUT : host_port_pkg::IO0_GP_OUT;
			io1_mode[c] = host_port_pkg::IO1_CT;
			{io0_gp_out, ct_out, pin1} = 12'($random(seed));
			nclk(4);
			check({multi_pin_zero_oe[c], multi_pin_zero_out[c]},
				{1'b1, c[1] ? tx_clk_16x[c] : io0_gp_out[c]});
			check({multi_pin_one_oe[c], ct_in[c]}, {c[0], c[0] ? 1'b0 : pin1[c]});
			if (c[0]) check(multi_pin_one_out[c], ct_out[c]);
			io0_mode[c] = host_port_pkg::IO0_CTS_IN;
			io1_mode[c] = c[1] ? host_port_pkg::IO1_TXC16_IN : host_port_pkg::IO1_TXC1_IN;
			// settle first: the mode switch itself can move the pin
			nclk(8);
			pin0[c] = ~pin0[c];
			pin1[c] = ~pin1[c];
			{acked, oe_seen} = 2'b00;
			for (k = 0; k < 8; k++) begin
				nclk(1);
				acked |= (io0_cos[c] === 1'b1);
				oe_seen |= (io1_cos[c] === 1'b1);
			end
			check({acked, oe_seen, cts_n[c], ext_tx_clk[c], ext_tx_16x[c], io0_level[c], io1_level[c]},
				{2'b11, pin0[c], pin1[c], c[1], pin0[c], pin1[c]});
			io0_mode[c] = host_port_pkg::IO0_GP_IN;
			io1_mode[c] = host_port_pkg::IO1_GP_IN;
		end
		d = 8'($random(seed)) | 8'h80;
		{osc_div_wdata, osc_div_wr} = {d, 1'b1};
		nclk(1);
		{osc_div_wr, dack_disable} = 2'b01;
		nclk(1);
		dack_disable = 1'b0;
		nclk(1);
		check({osc_div, dack_enable}, {d, 1'b0});
		host.cycle(0, 6'h00, 8'h00, rd, acked, oe_seen, released);
		check({acked, released}, 2'b01);
		master_reset = 1'b1;
		nclk(4);
		master_reset = 1'b0;
		nclk(3);
		check({osc_div, mr_ptr, dack_enable, multi_pin_zero_oe, multi_pin_one_oe}, {8'h01, 3'h1, 8'h00});
		wrap_up;
	end
endmodule // host_bus_port_tb

// [bench/host_model.sv]
// host processor model on the asynchronous register bus
`timescale 1ns/1ns
module host_model (
	// clock
	input  wire logic       clk_sys,
	// host pins
	output logic            chip_select_n,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic            irq_ack_in_n,
	output logic [5:0]      reg_addr_in,
	output logic [7:0]      host_data_in,
	input  wire logic [7:0] host_data_out,
	input  wire logic       host_data_oe,
	input  wire logic       bus_ack_n_oe
);
	// ==========================================
	// bus wires
	logic       drive_q;
	logic [7:0] wval;
	logic [7:0] last_q;
	// open-drain acknowledge with pull-up
	wire        bus_ack_n = !bus_ack_n_oe;
	initial begin
		{chip_select_n, read_strobe_n, write_strobe_n, irq_ack_in_n} = 4'hf;
		reg_addr_in = 6'h00;
		drive_q = 1'b0;
		wval = 8'h00;
		last_q = 8'h00;
	end
	// released bus keeps flipping, so a stale value never matches by luck
	always @(posedge clk_sys) last_q <= host_data_in;
	assign host_data_in = host_data_oe ? host_data_out : drive_q ? wval : ~last_q;
	// ==========================================
	// one bus cycle: kind 0 read, 1 write, 2 interrupt acknowledge
	task automatic cycle(input int kind, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] rd, output bit acked, output bit oe_seen, output bit released);
		int n;
		@(negedge clk_sys);
		reg_addr_in = a;
		wval = d;
		drive_q = (kind == 1);
		chip_select_n = (kind == 2);
		read_strobe_n = (kind != 0);
		write_strobe_n = (kind != 1);
		irq_ack_in_n = (kind != 2);
		acked = 1'b0;
		rd = 8'h00;
		oe_seen = 1'b0;
		// request held until the edge that sees the acknowledge
		for (n = 0; n < 12 && !acked; n++) begin
			@(posedge clk_sys);
			acked = (bus_ack_n === 1'b0);
			rd = host_data_in;
			oe_seen = (host_data_oe === 1'b1);
		end
		@(negedge clk_sys);
		{chip_select_n, read_strobe_n, write_strobe_n, irq_ack_in_n} = 4'hf;
		drive_q = 1'b0;
		repeat (6) @(posedge clk_sys);
		released = (host_data_oe === 1'b0) && (bus_ack_n === 1'b1);
		// hand back on a falling edge so the caller's stimulus stays off the sampling edge
		@(negedge clk_sys);
	endtask
endmodule // host_model

// [include/host_port_defines.svh]
// constants for the parallel host port and pin functions
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
// ==========================================
// widths
`define HP_ADDR_W      6
`define HP_DATA_W      8
`define HP_NCH         4
`define HP_LVL_W       6
// ==========================================
// reset values, and the last value the mode register pointer parks on
`define HP_OSC_DIV_RST 8'h01
`define HP_MR_PTR_RST  2'h0
`define HP_MR_PTR_LAST 2'h2
`define HP_DACK_EN_RST 1'b1
// ==========================================
// field positions
`define HP_MR_ADDR_LO  3'h0
`define HP_VEC_CH_LSB  0
`define HP_VEC_CH_MSB  1
`endif

// [include/host_port_pkg.sv]
// types for the parallel host port and pin functions
package host_port_pkg;
	// ==========================================
	// pin modes
	typedef enum logic [2:0] {
		IO0_GP_IN,
		IO0_CTS_IN,
		IO0_TXC1_OUT,
		IO0_TXC16_OUT,
		IO0_GP_OUT
	} io0_mode_type;

	typedef enum logic [2:0] {
		IO1_GP_IN,
		IO1_TXC1_IN,
		IO1_TXC16_IN,
		IO1_RXC1_OUT,
		IO1_RXC16_OUT,
		IO1_GP_OUT,
		IO1_CT
	} io1_mode_type;

	// ==========================================
	// host cycle sequencer
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_ACK
	} host_state_type;
endpackage

// [logic/host_bus_port.sv]
// asynchronous-strobe parallel host port with interrupt acknowledge and pin functions
// Contract
// RULE_01: access needs chip select plus read or write
// RULE_02: address inputs select the target register
// RULE_03: eight-bit bus, driven only on reads/acknowledge
// RULE_04: read cycle drives addressed register data
// RULE_05: write cycle stores bus into addressed register
// RULE_06: acknowledge pulled low after each access
// RULE_07: read acknowledge only once data valid
// RULE_08: write acknowledge only after data captured
// RULE_09: interrupt request when enabled level exceeds threshold
// RULE_10: host holds chip select high during acknowledge
// RULE_11: acknowledge returns vector, plain or modified
// RULE_12: each acknowledge updates current interrupt register
// RULE_13: four channels, one transmit, one receive each
// RULE_14: pin zero modes and change detection
// RULE_15: pin one modes and change detection
// RULE_16: pin one carries timer in a/c, out b/d
// RULE_17: master reset sets divider, pointer, acknowledge, inputs
// RULE_18: release acknowledge and bus when strobe rises
`timescale 1ns/1ns
`include "host_port_defines.svh"
module host_bus_port #(
	parameter int NCH   = `HP_NCH,
	parameter int LVL_W = `HP_LVL_W
) (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire logic                        master_reset,
	// host pins
	input  wire logic                        chip_select_n,
	input  wire logic                        read_strobe_n,
	input  wire logic                        write_strobe_n,
	input  wire logic                        irq_ack_in_n,
	input  wire logic [`HP_ADDR_W-1:0]       reg_addr_in,
	input  wire logic [`HP_DATA_W-1:0]       host_data_in,
	output logic      [`HP_DATA_W-1:0]       host_data_out,
	output logic                             host_data_oe,
	output logic                             bus_ack_n_out,
	output logic                             bus_ack_n_oe,
	output logic                             irq_out_n_out,
	output logic                             irq_out_n_oe,
	// register file side
	output logic                             reg_rd_stb,
	output logic                             reg_wr_stb,
	output logic      [`HP_ADDR_W-1:0]       reg_addr,
	output logic      [`HP_DATA_W-1:0]       reg_wdata,
	input  wire logic [`HP_DATA_W-1:0]       reg_rdata,
	// control
	input  wire logic                        osc_div_wr,
	input  wire logic [7:0]                  osc_div_wdata,
	input  wire logic                        dack_disable,
	output logic      [7:0]                  osc_div,
	output logic      [1:0]                  mr_ptr,
	output logic                             dack_enable,
	// interrupt sources
	input  wire logic [NCH-1:0][LVL_W-1:0]   src_level,
	input  wire logic [NCH-1:0]              src_enable,
	input  wire logic [LVL_W-1:0]            irq_threshold,
	input  wire logic [`HP_DATA_W-1:0]       irq_vector,
	input  wire logic                        vector_modify,
	output logic      [`HP_DATA_W-1:0]       current_interrupt_reg,
	// serial pins
	output logic      [NCH-1:0]              serial_tx_out,
	input  wire logic [NCH-1:0]              serial_rx_in,
	input  wire logic [NCH-1:0]              chan_tx_data,
	output logic      [NCH-1:0]              chan_rx_data,
	// multi-use pins
	input  wire host_port_pkg::io0_mode_type io0_mode [NCH],
	input  wire host_port_pkg::io1_mode_type io1_mode [NCH],
	input  wire logic [NCH-1:0]              io0_gp_out,
	input  wire logic [NCH-1:0]              io1_gp_out,
	input  wire logic [NCH-1:0]              tx_clk_1x,
	input  wire logic [NCH-1:0]              tx_clk_16x,
	input  wire logic [NCH-1:0]              rx_clk_1x,
	input  wire logic [NCH-1:0]              rx_clk_16x,
	input  wire logic [NCH-1:0]              ct_out,
	input  wire logic [NCH-1:0]              multi_pin_zero_in,
	output logic      [NCH-1:0]              multi_pin_zero_out,
	output logic      [NCH-1:0]              multi_pin_zero_oe,
	input  wire logic [NCH-1:0]              multi_pin_one_in,
	output logic      [NCH-1:0]              multi_pin_one_out,
	output logic      [NCH-1:0]              multi_pin_one_oe,
	output logic      [NCH-1:0]              io0_level,
	output logic      [NCH-1:0]              io1_level,
	output logic      [NCH-1:0]              io0_cos,
	output logic      [NCH-1:0]              io1_cos,
	output logic      [NCH-1:0]              cts_n,
	output logic      [NCH-1:0]              ext_tx_clk,
	output logic      [NCH-1:0]              ext_tx_16x,
	output logic      [NCH-1:0]              ct_in
);
	// ==========================================
	// parameter check
	if (NCH != 4 || LVL_W < 1 || LVL_W > 6) begin : g_bad_param
		$error("host_bus_port needs four channels and a level of 1 to 6 bits");
	end

	localparam int SW = 5 + `HP_ADDR_W + `HP_DATA_W + NCH;

	// ==========================================
	// pin synchronisers
	logic [SW-1:0] meta_q;
	logic [SW-1:0] sync_q;

	always_ff @(posedge clk_sys) begin
		meta_q <= {master_reset, chip_select_n, read_strobe_n, write_strobe_n,
			irq_ack_in_n, reg_addr_in, host_data_in, serial_rx_in};
		sync_q <= meta_q;
	end

	wire                  mreset_s = sync_q[SW-1];
	wire                  cs_n_s   = sync_q[SW-2];
	wire                  rd_n_s   = sync_q[SW-3];
	wire                  wr_n_s   = sync_q[SW-4];
	wire                  iack_n_s = sync_q[SW-5];
	wire [`HP_ADDR_W-1:0] addr_s   = sync_q[`HP_DATA_W+NCH +: `HP_ADDR_W];
	wire [`HP_DATA_W-1:0] data_s   = sync_q[NCH +: `HP_DATA_W];
	wire                  srst     = !rst_n || mreset_s; // [RULE_17]

	// ==========================================
	// cycle decode
	wire rd_req   = !cs_n_s && !rd_n_s; // [RULE_01]
	wire wr_req   = !cs_n_s && !wr_n_s && rd_n_s; // [RULE_01]
	// an acknowledge seen with chip select low is ignored
	wire iack_req = !iack_n_s && cs_n_s; // [RULE_10]
	wire all_idle = rd_n_s && wr_n_s && iack_n_s;

	// ==========================================
	// interrupt arbitration
	function automatic logic [1:0] pick_winner(input logic [NCH-1:0][LVL_W-1:0] lv,
		input logic [NCH-1:0] en);
		logic [1:0]       best;
		logic [LVL_W-1:0] top;
		best = 2'h0;
		top  = '0;
		for (int i = 0; i < NCH; i++) begin
			if (en[i] && lv[i] > top) begin
				best = 2'(i);
				top  = lv[i];
			end
		end
		return best;
	endfunction

	logic [NCH-1:0] hit;
	for (genvar c = 0; c < NCH; c++) begin : g_hit
		assign hit[c] = src_enable[c] && (src_level[c] > irq_threshold); // [RULE_09]
	end
	wire                  any_hit  = |hit;
	wire [1:0]            win_ch   = pick_winner(src_level, hit);
	wire [LVL_W-1:0]      win_lvl  = src_level[win_ch];
	wire [`HP_DATA_W-1:0] vec_mod  = {irq_vector[`HP_DATA_W-1:`HP_VEC_CH_MSB+1], win_ch};
	wire [`HP_DATA_W-1:0] vec_sel  = vector_modify ? vec_mod : irq_vector; // [RULE_11]
	wire [`HP_DATA_W-1:0] cir_next = `HP_DATA_W'({win_ch, win_lvl});

	// ==========================================
	// cycle sequencer
	host_port_pkg::host_state_type state_q;
	host_port_pkg::host_state_type state_d;
	logic                          wr_cycle_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			host_port_pkg::ST_IDLE: begin
				// writes pass the fetch state too, so the store lands before the ack
				if (rd_req || wr_req) begin
					state_d = host_port_pkg::ST_FETCH; // [RULE_08]
				end else if (iack_req) begin
					state_d = host_port_pkg::ST_ACK;
				end
			end
			host_port_pkg::ST_FETCH: begin
				state_d = host_port_pkg::ST_ACK;
			end
			host_port_pkg::ST_ACK: begin
				if (all_idle) begin
					state_d = host_port_pkg::ST_IDLE; // [RULE_18]
				end
			end
		endcase
	end

	wire idle      = (state_q == host_port_pkg::ST_IDLE);
	wire take_rd   = idle && rd_req;
	wire take_wr   = idle && !rd_req && wr_req;
	wire take_iack = idle && !rd_req && !wr_req && iack_req;
	wire mr_access = (take_rd || take_wr) && (addr_s[2:0] == `HP_MR_ADDR_LO);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q    <= host_port_pkg::ST_IDLE;
			wr_cycle_q <= 1'b0;
			reg_rd_stb <= 1'b0;
			reg_wr_stb <= 1'b0;
		end else begin
			state_q    <= state_d;
			wr_cycle_q <= take_wr ? 1'b1 : (idle ? 1'b0 : wr_cycle_q);
			reg_rd_stb <= take_rd; // [RULE_04]
			reg_wr_stb <= take_wr; // [RULE_05]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			reg_addr  <= '0;
			reg_wdata <= '0;
		end else if (take_rd || take_wr) begin
			reg_addr  <= addr_s; // [RULE_02]
			reg_wdata <= data_s; // [RULE_05]
		end
	end

	// ==========================================
	// data bus and acknowledge drive
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			host_data_out <= '0;
			host_data_oe  <= 1'b0;
		end else if (state_q == host_port_pkg::ST_FETCH && !wr_cycle_q) begin
			host_data_out <= reg_rdata; // [RULE_04]
			host_data_oe  <= 1'b1; // [RULE_03]
		end else if (take_iack) begin
			host_data_out <= vec_sel; // [RULE_11]
			host_data_oe  <= 1'b1;
		end else if (state_q == host_port_pkg::ST_ACK && all_idle) begin
			host_data_oe  <= 1'b0; // [RULE_18]
		end
	end

	// data is already stable when the sequencer reaches the acknowledge state
	assign bus_ack_n_oe  = (state_q == host_port_pkg::ST_ACK) && dack_enable; // [RULE_06] [RULE_07] [RULE_08]
	assign bus_ack_n_out = 1'b0;
	assign irq_out_n_out = 1'b0;

	// ==========================================
	// interrupt output and current interrupt
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_out_n_oe          <= 1'b0;
			current_interrupt_reg <= '0;
		end else begin
			irq_out_n_oe <= any_hit; // [RULE_09]
			if (take_iack) begin
				current_interrupt_reg <= cir_next; // [RULE_12]
			end
		end
	end

	// ==========================================
	// reset-set control
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			osc_div     <= `HP_OSC_DIV_RST; // [RULE_17]
			mr_ptr      <= `HP_MR_PTR_RST;
			dack_enable <= `HP_DACK_EN_RST;
		end else begin
			if (osc_div_wr) begin
				osc_div <= osc_div_wdata;
			end
			if (dack_disable) begin
				dack_enable <= 1'b0;
			end
			// pointer steps through the mode registers and parks on the last
			if (mr_access && mr_ptr != `HP_MR_PTR_LAST) begin
				mr_ptr <= mr_ptr + 2'h1;
			end
		end
	end

	// ==========================================
	// serial pins and multi-use pins
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			serial_tx_out <= '1;
		end else begin
			serial_tx_out <= chan_tx_data; // [RULE_13]
		end
	end
	assign chan_rx_data = sync_q[NCH-1:0]; // [RULE_13]

	for (genvar c = 0; c < NCH; c++) begin : g_chan
		multi_pin_cell #(
			.CT_IS_OUTPUT ((c % 2) == 1) // [RULE_16]
		) u_pins (
			.clk_sys    (clk_sys),
			.srst       (srst),
			.io0_mode   (io0_mode[c]),
			.io1_mode   (io1_mode[c]),
			.io0_gp_out (io0_gp_out[c]),
			.io1_gp_out (io1_gp_out[c]),
			.tx_clk_1x  (tx_clk_1x[c]),
			.tx_clk_16x (tx_clk_16x[c]),
			.rx_clk_1x  (rx_clk_1x[c]),
			.rx_clk_16x (rx_clk_16x[c]),
			.ct_out     (ct_out[c]),
			.io0_in     (multi_pin_zero_in[c]),
			.io0_out    (multi_pin_zero_out[c]),
			.io0_oe     (multi_pin_zero_oe[c]),
			.io1_in     (multi_pin_one_in[c]),
			.io1_out    (multi_pin_one_out[c]),
			.io1_oe     (multi_pin_one_oe[c]),
			.io0_level  (io0_level[c]),
			.io1_level  (io1_level[c]),
			.io0_cos    (io0_cos[c]),
			.io1_cos    (io1_cos[c]),
			.cts_n      (cts_n[c]),
			.ext_tx_clk (ext_tx_clk[c]),
			.ext_tx_16x (ext_tx_16x[c]),
			.ct_in      (ct_in[c])
		);
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	AST_ACK_NEEDS_CYCLE: assert property ($rose(bus_ack_n_oe) |-> $past(!all_idle)) // [RULE_01]
		else $error("acknowledge without a host cycle");
	AST_RD_ADDR: assert property (reg_rd_stb |-> reg_addr == $past(addr_s)) // [RULE_02]
		else $error("read address not taken from the bus");
	AST_NO_DRIVE_WRITE: assert property (wr_cycle_q |-> !host_data_oe) // [RULE_03]
		else $error("data bus driven during a write");
	AST_RD_DATA: assert property (reg_rd_stb |-> ##2 (host_data_oe && host_data_out == $past(reg_rdata))) // [RULE_04]
		else $error("read data not presented");
	AST_WR_DATA: assert property (take_wr |=> reg_wr_stb && reg_wdata == $past(data_s)) // [RULE_05]
		else $error("write data not stored");
	AST_RD_ACK_VALID: assert property (bus_ack_n_oe && !wr_cycle_q |-> host_data_oe) // [RULE_07]
		else $error("read acknowledge before data valid");
	AST_WR_ACK_LATE: assert property ($rose(bus_ack_n_oe) && wr_cycle_q |-> $past(reg_wr_stb)) // [RULE_08]
		else $error("write acknowledge before capture");
	AST_ACK_SERVICED: assert property ((take_rd && dack_enable && !dack_disable) |-> ##2 bus_ack_n_oe) // [RULE_06]
		else $error("access not acknowledged");
	AST_IRQ: assert property (any_hit |=> irq_out_n_oe) // [RULE_09]
		else $error("interrupt request missing");
	AST_VECTOR: assert property (take_iack |=> host_data_out == $past(vec_sel) ##0 bus_ack_n_oe == dack_enable) // [RULE_11]
		else $error("vector not driven on acknowledge");
	AST_CIR: assert property (take_iack |=> current_interrupt_reg == $past(cir_next)) // [RULE_12]
		else $error("current interrupt not updated");
	AST_RELEASE: assert property (state_q == host_port_pkg::ST_ACK && all_idle |=> !host_data_oe && !bus_ack_n_oe) // [RULE_18]
		else $error("bus not released after strobe");
	AST_RESET_VAL: assert property ($fell(srst) |-> osc_div == `HP_OSC_DIV_RST && mr_ptr == `HP_MR_PTR_RST && dack_enable) // [RULE_17]
		else $error("reset values wrong");

	COV_READ: cover property (take_rd ##[1:4] bus_ack_n_oe);
	COV_WRITE: cover property (take_wr ##[1:4] bus_ack_n_oe);
	COV_IACK: cover property (take_iack && vector_modify);
endmodule // host_bus_port

// [logic/multi_pin_cell.sv]
// one channel's two multi-use pins with change-of-state detection
`timescale 1ns/1ns
`include "host_port_defines.svh"
module multi_pin_cell #(
	parameter bit CT_IS_OUTPUT = 1'b0
) (
	// clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        srst,
	// configuration
	input  wire host_port_pkg::io0_mode_type io0_mode,
	input  wire host_port_pkg::io1_mode_type io1_mode,
	input  wire logic                        io0_gp_out,
	input  wire logic                        io1_gp_out,
	// internal clocks and timer
	input  wire logic                        tx_clk_1x,
	input  wire logic                        tx_clk_16x,
	input  wire logic                        rx_clk_1x,
	input  wire logic                        rx_clk_16x,
	input  wire logic                        ct_out,
	// pins
	input  wire logic                        io0_in,
	output logic                             io0_out,
	output logic                             io0_oe,
	input  wire logic                        io1_in,
	output logic                             io1_out,
	output logic                             io1_oe,
	// user side
	output logic                             io0_level,
	output logic                             io1_level,
	output logic                             io0_cos,
	output logic                             io1_cos,
	output logic                             cts_n,
	output logic                             ext_tx_clk,
	output logic                             ext_tx_16x,
	output logic                             ct_in
);
	// ==========================================
	// input synchronisers and change detect
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] last_q;
	logic [1:0] cos_q;

	// history not reset: a pin that moved during reset gives no false change
	always_ff @(posedge clk_sys) begin
		meta_q <= {io1_in, io0_in};
		sync_q <= meta_q;
		last_q <= sync_q;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cos_q <= 2'h0;
		end else begin
			cos_q <= sync_q ^ last_q; // [RULE_14] [RULE_15]
		end
	end

	assign io0_level = sync_q[0];
	assign io1_level = sync_q[1];
	assign io0_cos   = cos_q[0];
	assign io1_cos   = cos_q[1];

	// ==========================================
	// mode decode
	wire io0_drives = (io0_mode == host_port_pkg::IO0_TXC1_OUT) ||
		(io0_mode == host_port_pkg::IO0_TXC16_OUT) ||
		(io0_mode == host_port_pkg::IO0_GP_OUT); // [RULE_14]
	wire io0_value  = (io0_mode == host_port_pkg::IO0_TXC1_OUT) ? tx_clk_1x :
		(io0_mode == host_port_pkg::IO0_TXC16_OUT) ? tx_clk_16x : io0_gp_out;
	wire io1_ct     = (io1_mode == host_port_pkg::IO1_CT);
	wire io1_drives = (io1_mode == host_port_pkg::IO1_RXC1_OUT) ||
		(io1_mode == host_port_pkg::IO1_RXC16_OUT) ||
		(io1_mode == host_port_pkg::IO1_GP_OUT) ||
		(io1_ct && CT_IS_OUTPUT); // [RULE_15] [RULE_16]
	wire io1_value  = (io1_mode == host_port_pkg::IO1_RXC1_OUT) ? rx_clk_1x :
		(io1_mode == host_port_pkg::IO1_RXC16_OUT) ? rx_clk_16x :
		io1_ct ? ct_out : io1_gp_out;

	// outputs go through flops so a mode change cannot glitch a pin
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			io0_oe  <= 1'b0;
			io1_oe  <= 1'b0;
			io0_out <= 1'b1;
			io1_out <= 1'b1;
		end else begin
			io0_oe  <= io0_drives;
			io1_oe  <= io1_drives;
			io0_out <= io0_value;
			io1_out <= io1_value;
		end
	end

	// inputs read as low when the pin is not in that mode
	assign cts_n      = (io0_mode == host_port_pkg::IO0_CTS_IN) ? sync_q[0] : 1'b0;
	assign ext_tx_clk = ((io1_mode == host_port_pkg::IO1_TXC1_IN) ||
		(io1_mode == host_port_pkg::IO1_TXC16_IN)) ? sync_q[1] : 1'b0; // [RULE_15]
	assign ext_tx_16x = (io1_mode == host_port_pkg::IO1_TXC16_IN);
	assign ct_in      = (io1_ct && !CT_IS_OUTPUT) ? sync_q[1] : 1'b0; // [RULE_16]

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	AST_COS_IS_EDGE: assert property (io0_cos |-> $past(sync_q[0], 2) != $past(sync_q[0], 1)) // [RULE_14]
		else $error("change flag without a change on pin zero");
	AST_CT_DIR: assert property (io1_ct |=> (io1_oe == CT_IS_OUTPUT)) // [RULE_16]
		else $error("timer pin direction wrong");
	COV_COS: cover property (io1_cos);
endmodule // multi_pin_cell
